// ===== hdl/cajc_pkg.sv
// Package for the cam axis job control block: constants, codes and carrier structs
package cajc_pkg;

    // Job selection codes
    localparam logic [3:0] JOB_SET_ACTUAL = 4'h0;
    localparam logic [3:0] JOB_SIMULATION = 4'h2;

    // Operator error codes
    localparam logic [7:0] ERR_NONE       = 8'h00;
    localparam logic [7:0] ERR_BAD_JOB    = 8'h01;
    localparam logic [7:0] ERR_NOT_IMMED  = 8'h02;

    // Status word bit positions
    localparam int AXIS_SYNC_BIT  = 10;
    localparam int RUN_ECHO_BIT   = 8;
    localparam int STOP_ECHO_BIT  = 9;
    localparam int SIM_ACTIVE_BIT = 12;
    localparam int TRACK_EN_BIT   = 8;
    localparam int CAM_LSB        = 8;
    localparam int TRACK_ID_BIT   = 0;

    // Position in units of 0.001 mm, speed in 0.001 mm/min
    localparam int POS_W = 32;
    localparam int SPD_W = 32;

    // Position update tick: every 1 ms of a 100 MHz clock
    localparam int      CLK_HZ       = 100_000_000;
    localparam int      TICK_US      = 1000;
    localparam int      TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
    // Ticks per minute; speed per tick = speed / 60000
    localparam logic [SPD_W-1:0] TICKS_PER_MIN = 32'd60000;

    localparam int NUM_CAMS = 8;

    // Reset values
    localparam logic [POS_W-1:0] POS_RESET = '0;
    localparam logic [15:0]      WORD_RESET = 16'h0000;

    // Job mailbox contents
    typedef struct packed {
        logic [3:0]       sel;
        logic             immediate;
        logic             reverse;
        logic [POS_W-1:0] coord;
        logic [SPD_W-1:0] speed;
    } cajc_job_t;

    // One cam: switch-on window [start, stop) and start-edge interrupt select
    typedef struct packed {
        logic [POS_W-1:0] start;
        logic [POS_W-1:0] stop;
        logic             irq_sel;
    } cajc_cam_t;

    // Status words read back by the controller
    typedef struct packed {
        logic [15:0]      axis_status;
        logic [15:0]      image_word;
        logic [15:0]      sim_word;
        logic [15:0]      track_word;
        logic [15:0]      cam_word;
        logic [15:0]      track_id;
        logic [7:0]       op_error;
        logic [POS_W-1:0] actual;
    } cajc_status_t;

endpackage : cajc_pkg

// ===== hdl/cajc_cam_track.sv
// One cam track: cam states from the actual position and start-of-cam edge pulses
`timescale 1ns/1ps
`default_nettype none
module cajc_cam_track
(
    // Clock and reset
    input  wire logic                             i_clk,
    input  wire logic                             i_resetn,
    // Track control and position
    input  wire logic                             i_enable,
    input  wire logic [cajc_pkg::POS_W-1:0]       i_pos,
    input  wire cajc_pkg::cajc_cam_t [cajc_pkg::NUM_CAMS-1:0] i_cams,
    // Cam states and start edges
    output logic      [cajc_pkg::NUM_CAMS-1:0]    o_cam,
    output logic      [cajc_pkg::NUM_CAMS-1:0]    o_start_edge
);
    import cajc_pkg::*;

    typedef struct packed {
        logic [NUM_CAMS-1:0] cam;
        logic [NUM_CAMS-1:0] edge_p;
    } cajc_trk_state_t;

    cajc_trk_state_t state;
    cajc_trk_state_t next_state;

    function automatic logic in_window(input logic [POS_W-1:0] p, input cajc_cam_t c);
        in_window = (p >= c.start) && (p < c.stop);
    endfunction : in_window

    always_comb
    begin
        next_state = state;
        for (int i = 0; i < NUM_CAMS; i++)
        begin
            // Disabled track holds all cams off
            next_state.cam[i]    = i_enable && in_window(i_pos, i_cams[i]);
            next_state.edge_p[i] = next_state.cam[i] && !state.cam[i];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            state <= '0;
        else
            state <= next_state;
    end

    assign o_cam        = state.cam;
    assign o_start_edge = state.edge_p;

endmodule : cajc_cam_track
`default_nettype wire

// ===== hdl/cajc_axis.sv
// Axis job and control-bit handling with simulation and one cam track
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Set-actual-value job loads position from job data and sets axis synchronized in the same cycle.
// - Run echo follows transferred run bit; clears on next transfer with bit low.
// - Run bit with simulation job starts simulation and sets simulation-active flag.
// - Active simulation moves position at commanded speed and direction, no encoder.
// - Zero simulation speed leaves position unchanged while simulation stays active.
// - No cam of a track switches before that track is enabled.
// - Transferred track-enable request sets track-enabled flag.
// - Transferred removal of track-enable stops the track and clears its flag.
// - Enabled track reports its eight cam states in bits 8 to 15.
// - Track one identification bit sits at bit 0 of track-id word.
// - Operator error is zero after good job, nonzero code on rejection.
// - Immediate-mode job executes at the moment the run bit is set.
// - Stop bit with simulation job ends simulation; position stays put.
// - With cam interrupts enabled, crossing selected cam start raises process interrupt.
module cajc_axis
(
    // Clock and reset
    input  wire logic                              i_clk,
    input  wire logic                              i_resetn,
    // Control-signal transfer from the controller
    input  wire logic                              i_write_ctrl,
    input  wire logic                              i_run,
    input  wire logic                              i_stop,
    input  wire logic                              i_track_en_req,
    // Job mailbox and machine data
    input  wire cajc_pkg::cajc_job_t               i_job,
    input  wire logic                              i_cam_irq_en,
    input  wire cajc_pkg::cajc_cam_t [cajc_pkg::NUM_CAMS-1:0] i_cams,
    // Transfer handshake, status and interrupt
    output logic                                   o_write_done,
    output cajc_pkg::cajc_status_t                 o_status,
    output logic      [cajc_pkg::NUM_CAMS-1:0]     o_cam_out,
    output logic                                   o_process_irq
);
    import cajc_pkg::*;

    typedef struct packed {
        logic             run_img;
        logic             stop_img;
        logic             track_en;
        logic             sim_active;
        logic             sim_reverse;
        logic [SPD_W-1:0] sim_speed;
        logic [SPD_W-1:0] frac;
        logic             synced;
        logic [7:0]       op_error;
        logic [POS_W-1:0] pos;
        logic [16:0]      tick_cnt;
        logic             done;
        logic             irq;
    } cajc_axis_state_t;

    cajc_axis_state_t state;
    cajc_axis_state_t next_state;

    logic [NUM_CAMS-1:0] cam;
    logic [NUM_CAMS-1:0] start_edge;
    logic                tick;
    logic                run_rise;
    logic                stop_rise;
    logic                xfer_take;
    logic [NUM_CAMS-1:0] irq_hit;
    logic [SPD_W:0]      acc;
    logic [SPD_W-1:0]    step;

    function automatic logic [15:0] bit_word(input logic v, input int pos);
        bit_word = 16'(v) << pos;
    endfunction : bit_word

    // Result of a job started by a run edge; only immediate jobs may run
    function automatic logic [7:0] run_error(input cajc_job_t job);
        if (!job.immediate)
            run_error = ERR_NOT_IMMED;
        else if ((job.sel == JOB_SET_ACTUAL) || (job.sel == JOB_SIMULATION))
            run_error = ERR_NONE;
        else
            run_error = ERR_BAD_JOB;
    endfunction : run_error

    // Result of a stop edge; only a simulation job can be switched off
    function automatic logic [7:0] stop_error(input cajc_job_t job);
        if (job.sel == JOB_SIMULATION)
            stop_error = ERR_NONE;
        else
            stop_error = ERR_BAD_JOB;
    endfunction : stop_error

    // Track one; its cams follow the registered position one cycle later
    cajc_cam_track u_track
    (
        .i_clk        (i_clk),
        .i_resetn     (i_resetn),
        .i_enable     (state.track_en),
        .i_pos        (state.pos),
        .i_cams       (i_cams),
        .o_cam        (cam),
        .o_start_edge (start_edge)
    );

    // Free-running divider; the first step after a start lands within one period
    assign tick      = (state.tick_cnt == TICK_LAST);
    // A request still high while done stands is ignored, then re-latched harmlessly
    assign xfer_take = i_write_ctrl && !state.done;
    // Command edges seen only at a transfer
    assign run_rise  = xfer_take && i_run && !state.run_img;
    assign stop_rise = xfer_take && i_stop && !state.stop_img;

    // Selected cams whose start was crossed in this cycle
    always_comb
    begin
        for (int i = 0; i < NUM_CAMS; i++)
        begin
            irq_hit[i] = i_cam_irq_en && start_edge[i] && i_cams[i].irq_sel;
        end
    end

    always_comb
    begin
        next_state          = state;
        acc                 = '0;
        step                = '0;
        next_state.tick_cnt = tick ? '0 : 17'(state.tick_cnt + 17'h00001);
        next_state.done     = 1'b0;
        next_state.irq      = |irq_hit;

        // Transfer: latch images and track enable, acknowledge one cycle later
        if (xfer_take)
        begin
            next_state.run_img  = i_run;
            next_state.stop_img = i_stop;
            next_state.track_en = i_track_en_req;
            next_state.done     = 1'b1;
        end

        // Simulation advance on each tick with fractional carry
        if (state.sim_active && tick)
        begin
            acc = {1'b0, state.frac} + {1'b0, state.sim_speed};
            step = SPD_W'(acc / {1'b0, TICKS_PER_MIN});
            next_state.frac = SPD_W'(acc % {1'b0, TICKS_PER_MIN});
            // Zero speed gives zero step
            if (state.sim_reverse)
                next_state.pos = state.pos - step;
            else
                next_state.pos = state.pos + step;
        end

        // Jobs run at the run edge only in immediate mode; run beats a stop edge
        if (run_rise)
        begin
            next_state.op_error = run_error(i_job);
            if (i_job.immediate)
            begin
                unique case (i_job.sel)
                    JOB_SET_ACTUAL:
                    begin
                        next_state.pos    = i_job.coord;
                        next_state.frac   = '0;
                        next_state.synced = 1'b1;
                    end
                    JOB_SIMULATION:
                    begin
                        next_state.sim_active  = 1'b1;
                        next_state.sim_speed   = i_job.speed;
                        next_state.sim_reverse = i_job.reverse;
                    end
                    default:
                    begin
                        // Unknown selection only reports its error code
                    end
                endcase
            end
        end
        else if (stop_rise)
        begin
            next_state.op_error = stop_error(i_job);
            if (stop_error(i_job) == ERR_NONE)
            begin
                // Position is left where it stopped, even on a tick
                next_state.sim_active = 1'b0;
                next_state.frac       = '0;
                next_state.pos        = state.pos;
            end
        end
    end

    // Reset clears every image, flag and the position
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state          <= '0;
            state.pos      <= POS_RESET;
            state.op_error <= ERR_NONE;
        end
        else
            state <= next_state;
    end

    // Acknowledge and interrupt are one-cycle registered pulses
    assign o_write_done  = state.done;
    assign o_cam_out     = cam;
    assign o_process_irq = state.irq;

    always_comb
    begin
        o_status             = '0;
        o_status.axis_status = bit_word(state.synced, AXIS_SYNC_BIT);
        o_status.image_word  = bit_word(state.run_img, RUN_ECHO_BIT)
                             | bit_word(state.stop_img, STOP_ECHO_BIT);
        o_status.sim_word    = bit_word(state.sim_active, SIM_ACTIVE_BIT);
        o_status.track_word  = bit_word(state.track_en, TRACK_EN_BIT);
        o_status.cam_word    = WORD_RESET | (16'(cam) << CAM_LSB);
        o_status.track_id    = bit_word(state.track_en, TRACK_ID_BIT);
        o_status.op_error    = state.op_error;
        o_status.actual      = state.pos;
    end

endmodule : cajc_axis
`default_nettype wire

// ===== testbench/cajc_axis_props.sv
// Checker for the axis block ports
`timescale 1ns/1ps
`default_nettype none
module cajc_axis_props
(
    // Clock, reset and inputs
    input wire logic                   i_clk,
    input wire logic                   i_resetn,
    input wire logic                   i_write_ctrl,
    input wire logic                   i_run,
    input wire logic                   i_cam_irq_en,
    // Outputs
    input wire logic                   o_write_done,
    input wire cajc_pkg::cajc_status_t o_status,
    input wire logic [7:0]             o_cam_out,
    input wire logic                   o_process_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_taken;
        i_write_ctrl && !o_write_done;
    endsequence
    AST_ANSWER: assert property (s_taken |=> o_write_done)
        else $error("transfer not answered");
    AST_PULSE: assert property (o_write_done |=> !o_write_done)
        else $error("done longer than one cycle");
    AST_ECHO_ON: assert property ($rose(o_status.image_word[8]) |-> o_write_done && $past(i_run))
        else $error("run echo set without transfer");
    AST_ECHO_OFF: assert property ($fell(o_status.image_word[8]) |-> o_write_done && !$past(i_run))
        else $error("run echo cleared without transfer");
    AST_SYNC: assert property ($rose(o_status.axis_status[10]) |-> o_write_done)
        else $error("synced set outside a job");
    AST_SIM_ON: assert property ($rose(o_status.sim_word[12]) |-> o_write_done)
        else $error("simulation started outside a job");
    AST_NO_CAM: assert property (!o_status.track_word[8] |=> o_cam_out == 8'h00)
        else $error("cam switched on disabled track");
    AST_CAM_WORD: assert property (o_status.cam_word[15:8] == o_cam_out)
        else $error("cam word differs from cams");
    AST_TRACK_ID: assert property (o_status.track_id[0] == o_status.track_word[8])
        else $error("track id bit wrong");
    AST_IRQ: assert property (o_process_irq |-> $past(i_cam_irq_en)
        && (($past(o_cam_out) & ~$past(o_cam_out, 2)) != 8'h00))
        else $error("interrupt without cam start");
    AST_IRQ_QUIET: assert property (!i_cam_irq_en |=> !o_process_irq)
        else $error("interrupt while cam interrupts disabled");
    AST_STOP: assert property ($fell(o_status.sim_word[12]) |-> $stable(o_status.actual))
        else $error("position moved at stop");
endmodule : cajc_axis_props
`default_nettype wire

// ===== testbench/cajc_ctrl_model.sv
// Controller model: raises the write request with control bits, drops it on done
`timescale 1ns/1ps
`default_nettype none
module cajc_ctrl_model
(
    // Clock and handshake
    input  wire logic i_clk,
    input  wire logic i_write_done,
    // Control bits
    output logic      o_write_ctrl,
    output logic      o_run,
    output logic      o_stop,
    output logic      o_track_en_req
);
    initial
    begin
        {o_write_ctrl, o_run, o_stop, o_track_en_req} = 4'h0;
    end
    task automatic transfer(input logic run, stop, en, output logic ok);
        int n;
        @(posedge i_clk);
        #1;
        {o_run, o_stop, o_track_en_req} = {run, stop, en};
        o_write_ctrl = 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        while (i_write_done !== 1'b1 && n < 20);
        o_write_ctrl = 1'b0;
        ok = (n < 20);
    endtask : transfer
endmodule : cajc_ctrl_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the axis block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cajc_pkg::*;
    logic                     i_clk, i_resetn, i_write_ctrl, i_run, i_stop, i_track_en_req;
    logic                     i_cam_irq_en, o_write_done, o_process_irq, ok;
    cajc_job_t                i_job;
    cajc_cam_t [NUM_CAMS-1:0] i_cams;
    cajc_status_t             o_status;
    logic [7:0]               o_cam_out, exp_cam;
    int                       num_errors, checks, pos, n, n_irq;
    logic [3:0]               t_sel[3] = '{JOB_SET_ACTUAL, 4'h7, JOB_SET_ACTUAL};
    logic                     t_imm[3] = '{1'b0, 1'b1, 1'b1};
    logic                     t_stp[3] = '{1'b0, 1'b0, 1'b1};
    logic [7:0]               t_err[3] = '{ERR_NOT_IMMED, ERR_BAD_JOB, ERR_BAD_JOB};
    cajc_axis u_cajc_axis (.i_clk(i_clk), .i_resetn(i_resetn), .i_write_ctrl(i_write_ctrl),
        .i_run(i_run), .i_stop(i_stop), .i_track_en_req(i_track_en_req), .i_job(i_job),
        .i_cam_irq_en(i_cam_irq_en), .i_cams(i_cams), .o_write_done(o_write_done),
        .o_status(o_status), .o_cam_out(o_cam_out), .o_process_irq(o_process_irq));
    cajc_ctrl_model u_cajc_ctrl_model (.i_clk(i_clk), .i_write_done(o_write_done),
        .o_write_ctrl(i_write_ctrl), .o_run(i_run), .o_stop(i_stop),
        .o_track_en_req(i_track_en_req));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Count process interrupt pulses where they are settled
    always @(negedge i_clk)
        if (o_process_irq === 1'b1)
            n_irq++;
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp)
        begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk
    task automatic xfer(input logic run, stop, en);
        u_cajc_ctrl_model.transfer(run, stop, en, ok);
        chk("write_done", 32'h1, {31'h0, ok});
    endtask : xfer
    task automatic final_report;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial
    begin
        #1_100_000;
        num_errors++;
        final_report();
    end
    initial
    begin
        {i_resetn, i_cam_irq_en, i_job, i_cams} = '0;
        void'($urandom(64));
        repeat (3) @(posedge i_clk);
        #1 i_resetn = 1'b1;
        pos = ($urandom & 32'h000f_ffff) | 32'h1000;
        i_job = '{JOB_SET_ACTUAL, 1'b1, 1'b0, 32'(pos), 32'h0};
        xfer(1, 0, 0);
        chk("actual", 32'(pos), o_status.actual);
        chk("synced", 32'h1, 32'(o_status.axis_status[10]));
        chk("run echo", 32'h1, 32'(o_status.image_word[8]));
        chk("op_error", 32'(ERR_NONE), 32'(o_status.op_error));
        xfer(0, 0, 0);
        chk("run echo", 32'h0, 32'(o_status.image_word[8]));
        $display("test set_actual done");
        for (int t = 0; t < 3; t++)
        begin
            i_job = '{t_sel[t], t_imm[t], 1'b0, $urandom, 32'h0};
            xfer(!t_stp[t], t_stp[t], 0);
            chk("op_error", 32'(t_err[t]), 32'(o_status.op_error));
            chk("actual", 32'(pos), o_status.actual);
            xfer(0, 0, 0);
        end
        $display("test rejects done");
        i_job = '{JOB_SIMULATION, 1'b1, 1'b0, 32'h0, 32'd6000000};
        xfer(1, 0, 0);
        chk("sim active", 32'h1, 32'(o_status.sim_word[12]));
        xfer(0, 0, 0);
        n = 0;
        while (o_status.actual === 32'(pos) && n < 100100)
        begin
            @(posedge i_clk);
            #1 n++;
        end
        pos += 100;
        chk("actual", 32'(pos), o_status.actual);
        chk("cams", 32'h0, 32'(o_cam_out));
        $display("test simulation done");
        for (int k = 0; k < NUM_CAMS; k++)
        begin
            i_cams[k] = '{32'(pos - 100 + 30 * k), 32'(pos - 10 + 30 * k), 1'b1};
            exp_cam[k] = (30 * k <= 100) && (30 * k > 10);
        end
        i_cam_irq_en = 1'b1;
        xfer(0, 0, 1);
        chk("track en", 32'h1, 32'(o_status.track_word[8]));
        chk("track id", 32'h1, 32'(o_status.track_id[0]));
        repeat (2) @(posedge i_clk);
        #1 chk("cams", 32'(exp_cam), 32'(o_cam_out));
        chk("cam word", 32'(exp_cam), 32'(o_status.cam_word[15:8]));
        xfer(0, 1, 1);
        chk("sim active", 32'h0, 32'(o_status.sim_word[12]));
        chk("actual", 32'(pos), o_status.actual);
        xfer(0, 0, 0);
        chk("track en", 32'h0, 32'(o_status.track_word[8]));
        repeat (2) @(posedge i_clk);
        #1 chk("cams", 32'h0, 32'(o_cam_out));
        chk("irq count", 32'h1, 32'(n_irq));
        $display("test cam track done");
        final_report();
    end
endmodule : testbench
bind cajc_axis cajc_axis_props u_cajc_axis_props (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_write_ctrl(i_write_ctrl), .i_run(i_run), .i_cam_irq_en(i_cam_irq_en),
    .o_write_done(o_write_done), .o_status(o_status), .o_cam_out(o_cam_out),
    .o_process_irq(o_process_irq));
`default_nettype wire
